// ==== hw/frt_pkg.sv ====
// package for the free-running timer with two capture channels
// assumes an avalon-mm slave with 32-bit words, byte registers in low bits
package frt_pkg;
	// ----------------------------------------
	// register word offsets (byte addresses)
	// ----------------------------------------
	localparam logic [5:0] OFF_COUNT_HIGH = 6'h00;
	localparam logic [5:0] OFF_COUNT_LOW = 6'h04;
	localparam logic [5:0] OFF_SHADOW_HIGH = 6'h08;
	localparam logic [5:0] OFF_SHADOW_LOW = 6'h0C;
	localparam logic [5:0] OFF_CAP1_HIGH = 6'h10;
	localparam logic [5:0] OFF_CAP1_LOW = 6'h14;
	localparam logic [5:0] OFF_CAP2_HIGH = 6'h18;
	localparam logic [5:0] OFF_CAP2_LOW = 6'h1C;
	localparam logic [5:0] OFF_STATUS = 6'h20;
	localparam logic [5:0] OFF_CONTROL_ONE = 6'h24;
	localparam logic [5:0] OFF_CONTROL_TWO = 6'h28;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int BIT_ST_CAP1 = 7;
	localparam int BIT_ST_CAP2 = 4;
	localparam int BIT_ST_OVF = 5;
	localparam int BIT_C1_CAP_IE = 7;
	localparam int BIT_C1_OVF_IE = 5;
	localparam int BIT_C1_EDGE1 = 1;
	localparam int BIT_C2_OPM = 4;
	localparam int BIT_C2_PWM = 3;
	localparam int BIT_C2_CLK_HI = 3;
	localparam int BIT_C2_CLK_LO = 2;
	localparam int BIT_C2_EXT_EDGE = 0;
	localparam int BIT_C2_EDGE2 = 1;
	// ----------------------------------------
	// reset values and clock encodings
	// ----------------------------------------
	localparam logic [15:0] COUNT_RELOAD = 16'hFFFC;
	localparam logic [15:0] COUNT_TOP = 16'hFFFF;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [1:0] CLK_DIV4 = 2'h0;
	localparam logic [1:0] CLK_DIV2 = 2'h1;
	localparam logic [1:0] CLK_DIV8 = 2'h2;
	localparam logic [1:0] CLK_EXT = 2'h3;
	localparam logic [2:0] PRESC_MASK_DIV2 = 3'h1;
	localparam logic [2:0] PRESC_MASK_DIV4 = 3'h3;
	localparam logic [2:0] PRESC_MASK_DIV8 = 3'h7;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;

	typedef struct packed {
		logic [5:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
	} frt_bus_req_t;

	typedef struct packed {
		logic cap_ie;
		logic ovf_ie;
		logic edge1;
	} frt_ctl1_t;

	typedef struct packed {
		logic one_pulse_mode;
		logic pwm;
		logic [1:0] clk_sel;
		logic edge2;
		logic ext_edge;
	} frt_ctl2_t;
endpackage

// ==== hw/frt_timer.sv ====
// free-running 16-bit timer with two input capture channels
// assumes pins are asynchronous; bus master obeys avalon-mm waitrequest
//
// Functional notes
// RQ1 - sixteen bit up counter, high and low bytes
// RQ2 - shadow view low read keeps overflow flag
// RQ3 - writing either low byte reloads FFFC
// RQ4 - reset and reload value is FFFC
// RQ5 - prescale cpu clock by two, four, eight
// RQ6 - clock select 11 uses external clock pin
// RQ7 - 00 div4, 01 div2, 10 div8
// RQ8 - edge select picks external active transition
// RQ9 - external edges synchronised to cpu clock
// RQ10 - external clock below quarter cpu rate
// RQ11 - high read freezes low byte until low read
// RQ12 - lone low read returns live byte
// RQ13 - wrap FFFF to 0000 sets overflow flag
// RQ14 - overflow irq when enabled and unmasked
// RQ15 - overflow clears by status read, low access
// RQ16 - runs in wait, freezes in halt
// RQ17 - capture latches count on active edge
// RQ18 - per channel capture edge select bit
// RQ19 - capture sets flag, shared enable irq
// RQ20 - capture flag clears status read, low access
// RQ21 - high read inhibits capture until low read
// RQ22 - one pulse or pwm: only channel two
// RQ23 - capture pins always feed the timer
//
// Register access over Avalon-MM and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module frt_timer
	import frt_pkg::*;
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic ext_clock_pin,
	input wire logic capture_input_one,
	input wire logic capture_input_two,
	input wire logic cpu_condition_code,
	input wire logic halt_mode,
	output logic timer_irq
);
	import frt_pkg::*;

	frt_bus_req_t req;
	logic rd_ack;
	logic wr_ack;
	logic [15:0] count_value;
	logic [7:0] low_buffer;
	logic low_frozen;
	logic [2:0] presc;
	logic [2:0] ext_sync;
	logic [2:0] cap1_sync;
	logic [2:0] cap2_sync;
	logic tick;
	logic ovf_flag;
	logic ovf_armed;
	logic [1:0] cap_flag;
	logic [1:0] cap_armed;
	logic [1:0] cap_inhibit;
	logic [15:0] capture_one_value;
	logic [15:0] capture_two_value;
	logic [1:0] cap_event;
	frt_ctl1_t ctl1;
	frt_ctl2_t ctl2;
	logic [7:0] next_readdata;

	assign req = '{address: avs_address, read: avs_read, write: avs_write,
		writedata: avs_writedata};
	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	// one wait cycle per read so that read data come from a flip-flop
	logic rd_done;
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			rd_done <= 1'b0;
		else
			rd_done <= req.read && !rd_done;
	end
	assign avs_waitrequest = req.read && !rd_done;
	assign rd_ack = req.read && rd_done;
	assign wr_ack = req.write;

	function automatic logic hit(input logic [5:0] off);
		hit = req.address == off;
	endfunction
	// ----------------------------------------
	// prescaler and external clock
	// ----------------------------------------
	logic [2:0] presc_mask;
	always_comb
	begin
		case (ctl2.clk_sel)
			CLK_DIV2: presc_mask = PRESC_MASK_DIV2; // RQ7
			CLK_DIV8: presc_mask = PRESC_MASK_DIV8; // RQ7
			default: presc_mask = PRESC_MASK_DIV4; // RQ7
		endcase
	end
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			presc <= 3'h0;
		else if (!halt_mode)
			presc <= presc + 3'h1; // RQ16
	end
	// pins are double-flopped; only the second and third stages are compared
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			ext_sync <= 3'h0;
			cap1_sync <= 3'h0;
			cap2_sync <= 3'h0;
		end
		else
		begin
			ext_sync <= {ext_sync[1:0], ext_clock_pin}; // RQ9
			cap1_sync <= {cap1_sync[1:0], capture_input_one}; // RQ23
			cap2_sync <= {cap2_sync[1:0], capture_input_two}; // RQ23
		end
	end
	function automatic logic edge_seen(input logic [2:0] s, input logic rising);
		edge_seen = rising ? (s[1] && !s[2]) : (!s[1] && s[2]);
	endfunction
	// slower external clocks than a quarter of the cpu rate are assumed
	always_comb
	begin
		if (halt_mode)
			tick = 1'b0; // RQ16
		else if (ctl2.clk_sel == CLK_EXT)
			tick = edge_seen(ext_sync, ctl2.ext_edge); // RQ6 RQ8 RQ10
		else
			tick = (presc & presc_mask) == presc_mask; // RQ5
	end
	// ----------------------------------------
	// counter
	// ----------------------------------------
	logic low_write;
	assign low_write = wr_ack && (hit(OFF_COUNT_LOW) || hit(OFF_SHADOW_LOW));
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			count_value <= COUNT_RELOAD; // RQ4
		else if (low_write)
			count_value <= COUNT_RELOAD; // RQ3
		else if (tick)
			count_value <= count_value + 16'h0001; // RQ1
	end
	// shared buffer for both views; taken at the edge that registers the
	// high byte, so a carry between the two halves cannot tear the value
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			low_frozen <= 1'b0;
			low_buffer <= 8'h00;
		end
		else if (req.read && !rd_done && (hit(OFF_COUNT_HIGH) || hit(OFF_SHADOW_HIGH)))
		begin
			if (!low_frozen)
				low_buffer <= count_value[7:0]; // RQ11
			low_frozen <= 1'b1; // RQ11
		end
		else if (rd_ack && (hit(OFF_COUNT_LOW) || hit(OFF_SHADOW_LOW)))
			low_frozen <= 1'b0; // RQ11
	end
	// ----------------------------------------
	// overflow flag
	// ----------------------------------------
	logic status_read;
	logic count_low_access;
	logic ovf_event;
	assign status_read = rd_ack && hit(OFF_STATUS);
	assign count_low_access = (rd_ack || wr_ack) && hit(OFF_COUNT_LOW);
	assign ovf_event = tick && !low_write && count_value == COUNT_TOP;
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			ovf_flag <= 1'b0;
			ovf_armed <= 1'b0;
		end
		else
		begin
			if (ovf_event)
				ovf_flag <= 1'b1; // RQ13
			else if (ovf_armed && count_low_access)
				ovf_flag <= 1'b0; // RQ15 RQ2
			if (status_read && ovf_flag)
				ovf_armed <= 1'b1; // RQ15
			else if (count_low_access)
				ovf_armed <= 1'b0;
		end
	end
	// ----------------------------------------
	// capture channels
	// ----------------------------------------
	logic [1:0] cap_low_access;
	logic [1:0] cap_high_read;
	logic [1:0] cap_edge;
	assign cap_low_access[0] = (rd_ack || wr_ack) && hit(OFF_CAP1_LOW);
	assign cap_low_access[1] = (rd_ack || wr_ack) && hit(OFF_CAP2_LOW);
	assign cap_high_read[0] = rd_ack && hit(OFF_CAP1_HIGH);
	assign cap_high_read[1] = rd_ack && hit(OFF_CAP2_HIGH);
	assign cap_edge[0] = edge_seen(cap1_sync, ctl1.edge1); // RQ18
	assign cap_edge[1] = edge_seen(cap2_sync, ctl2.edge2); // RQ18
	assign cap_event[0] = cap_edge[0] && !cap_inhibit[0] && !(ctl2.one_pulse_mode || ctl2.pwm); // RQ22 RQ21
	assign cap_event[1] = cap_edge[1] && !cap_inhibit[1]; // RQ21
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_cap
			always_ff @(posedge clock or negedge resetn)
			begin
				if (!resetn)
				begin
					cap_flag[gi] <= 1'b0;
					cap_armed[gi] <= 1'b0;
					cap_inhibit[gi] <= 1'b0;
				end
				else
				begin
					if (cap_event[gi])
						cap_flag[gi] <= 1'b1; // RQ19
					else if (cap_armed[gi] && cap_low_access[gi])
						cap_flag[gi] <= 1'b0; // RQ20
					if (status_read && cap_flag[gi])
						cap_armed[gi] <= 1'b1; // RQ20
					else if (cap_low_access[gi])
						cap_armed[gi] <= 1'b0;
					if (cap_high_read[gi])
						cap_inhibit[gi] <= 1'b1; // RQ21
					else if (cap_low_access[gi])
						cap_inhibit[gi] <= 1'b0;
				end
			end
		end
	endgenerate
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			capture_one_value <= 16'h0000;
			capture_two_value <= 16'h0000;
		end
		else
		begin
			if (cap_event[0])
				capture_one_value <= count_value; // RQ17
			if (cap_event[1])
				capture_two_value <= count_value; // RQ17
		end
	end
	// ----------------------------------------
	// control registers
	// ----------------------------------------
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			ctl1 <= '0;
			ctl2 <= '0;
		end
		else if (wr_ack && hit(OFF_CONTROL_ONE))
		begin
			ctl1.cap_ie <= req.writedata[BIT_C1_CAP_IE];
			ctl1.ovf_ie <= req.writedata[BIT_C1_OVF_IE];
			ctl1.edge1 <= req.writedata[BIT_C1_EDGE1];
		end
		else if (wr_ack && hit(OFF_CONTROL_TWO))
		begin
			ctl2.one_pulse_mode <= req.writedata[BIT_C2_OPM + 3];
			ctl2.pwm <= req.writedata[BIT_C2_PWM + 3];
			ctl2.clk_sel <= req.writedata[BIT_C2_CLK_HI:BIT_C2_CLK_LO];
			ctl2.edge2 <= req.writedata[BIT_C2_EDGE2];
			ctl2.ext_edge <= req.writedata[BIT_C2_EXT_EDGE];
		end
	end
	// ----------------------------------------
	// read mux and interrupt
	// ----------------------------------------
	always_comb
	begin
		next_readdata = READ_UNMAPPED;
		case (req.address)
			OFF_COUNT_HIGH, OFF_SHADOW_HIGH: next_readdata = count_value[15:8];
			OFF_COUNT_LOW, OFF_SHADOW_LOW:
				next_readdata = low_frozen ? low_buffer : count_value[7:0]; // RQ11 RQ12
			OFF_CAP1_HIGH: next_readdata = capture_one_value[15:8];
			OFF_CAP1_LOW: next_readdata = capture_one_value[7:0];
			OFF_CAP2_HIGH: next_readdata = capture_two_value[15:8];
			OFF_CAP2_LOW: next_readdata = capture_two_value[7:0];
			OFF_STATUS:
			begin
				next_readdata[BIT_ST_CAP1] = cap_flag[0];
				next_readdata[BIT_ST_CAP2] = cap_flag[1];
				next_readdata[BIT_ST_OVF] = ovf_flag;
			end
			OFF_CONTROL_ONE:
			begin
				next_readdata[BIT_C1_CAP_IE] = ctl1.cap_ie;
				next_readdata[BIT_C1_OVF_IE] = ctl1.ovf_ie;
				next_readdata[BIT_C1_EDGE1] = ctl1.edge1;
			end
			OFF_CONTROL_TWO:
			begin
				next_readdata[BIT_C2_OPM + 3] = ctl2.one_pulse_mode;
				next_readdata[BIT_C2_PWM + 3] = ctl2.pwm;
				next_readdata[BIT_C2_CLK_HI:BIT_C2_CLK_LO] = ctl2.clk_sel;
				next_readdata[BIT_C2_EDGE2] = ctl2.edge2;
				next_readdata[BIT_C2_EXT_EDGE] = ctl2.ext_edge;
			end
			default: next_readdata = READ_UNMAPPED;
		endcase
	end
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			avs_readdata <= 32'h0000_0000;
		else if (req.read && !rd_done)
			avs_readdata <= {24'h00_0000, next_readdata};
	end
	// pending flags stay set; the cpu mask only gates the request
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			timer_irq <= 1'b0;
		else
			timer_irq <= !cpu_condition_code && ((ctl1.ovf_ie && ovf_flag) ||
				(ctl1.cap_ie && |cap_flag)); // RQ14 RQ19
	end
	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_reload;
		@(posedge clock) disable iff (!resetn) low_write |=> count_value == COUNT_RELOAD;
	endproperty
	a_reload: assert property (p_reload) else $error("low write did not reload"); // RQ3
	property p_wrap;
		@(posedge clock) disable iff (!resetn) ovf_event |=> ovf_flag && count_value == 16'h0000;
	endproperty
	a_wrap: assert property (p_wrap) else $error("wrap did not set flag"); // RQ13
	property p_shadow_keeps;
		@(posedge clock) disable iff (!resetn)
			ovf_flag && rd_ack && hit(OFF_SHADOW_LOW) |=> ovf_flag;
	endproperty
	a_shadow_keeps: assert property (p_shadow_keeps) else $error("shadow read cleared flag"); // RQ2
	property p_ovf_clear;
		@(posedge clock) disable iff (!resetn)
			$fell(ovf_flag) |-> $past(ovf_armed) && $past(count_low_access);
	endproperty
	a_ovf_clear: assert property (p_ovf_clear) else $error("overflow cleared early"); // RQ15
	property p_halt;
		@(posedge clock) disable iff (!resetn)
			halt_mode && !low_write |=> $stable(count_value);
	endproperty
	a_halt: assert property (p_halt) else $error("counter moved in halt"); // RQ16
	property p_cap_latch;
		@(posedge clock) disable iff (!resetn)
			cap_event[1] |=> capture_two_value == $past(count_value) && cap_flag[1];
	endproperty
	a_cap_latch: assert property (p_cap_latch) else $error("capture two not latched"); // RQ17
	// watched on the register and flag, not on the gating term itself
	property p_inhibit;
		@(posedge clock) disable iff (!resetn)
			cap_inhibit[0] |=> $stable(capture_one_value) && !$rose(cap_flag[0]);
	endproperty
	a_inhibit: assert property (p_inhibit) else $error("capture while inhibited"); // RQ21
	property p_opm;
		@(posedge clock) disable iff (!resetn)
			(ctl2.one_pulse_mode || ctl2.pwm) |=> $stable(capture_one_value) && !$rose(cap_flag[0]);
	endproperty
	a_opm: assert property (p_opm) else $error("channel one in waveform mode"); // RQ22
	sequence s_tick_div2;
		!halt_mode && ctl2.clk_sel == CLK_DIV2 && !low_write && tick;
	endsequence
	property p_div2;
		@(posedge clock) disable iff (!resetn)
			s_tick_div2 ##1 (!halt_mode && ctl2.clk_sel == CLK_DIV2) |-> !tick;
	endproperty
	a_div2: assert property (p_div2) else $error("div2 ticked twice"); // RQ5
	property p_irq;
		@(posedge clock) disable iff (!resetn)
			ovf_flag && ctl1.ovf_ie && !cpu_condition_code |=> timer_irq || !ovf_flag;
	endproperty
	a_irq: assert property (p_irq) else $error("overflow irq missing"); // RQ14
endmodule // frt_timer
`default_nettype wire

// ==== test/frt_pins_model.sv ====
// pin-side model: external count clock and the two capture pins
// assumes its tasks are called from a process synchronous to clock
`timescale 1ns/1ps
`default_nettype none
module frt_pins_model
(
	input wire logic clock,
	output logic ext_clock_pin,
	output logic capture_input_one,
	output logic capture_input_two
);
	initial
	begin
		ext_clock_pin = 1'b0;
		capture_input_one = 1'b0;
		capture_input_two = 1'b0;
	end
	// count clock stands low between bursts; six clocks a phase keeps
	// active edges far enough apart for the synchroniser
	task automatic ext_pulses(input int n);
		repeat (n)
		begin
			@(posedge clock);
			ext_clock_pin <= 1'b1;
			repeat (6) @(posedge clock);
			ext_clock_pin <= 1'b0;
			repeat (6) @(posedge clock);
		end
	endtask
	// waits out the pin synchroniser before handing back
	task automatic cap_level(input int ch, input logic v);
		@(posedge clock);
		if (ch == 1)
			capture_input_one <= v;
		else
			capture_input_two <= v;
		repeat (8) @(posedge clock);
	endtask
endmodule // frt_pins_model
`default_nettype wire

// ==== test/frt_timer_test.sv ====
// testbench for the free-running timer with two capture channels
// assumes frt_pins_model drives the pins; bus is avalon-mm
`timescale 1ns/1ps
`default_nettype none
module frt_timer_test;
	import frt_pkg::*;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic [5:0] avs_address = 6'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic ext_clock_pin;
	logic capture_input_one;
	logic capture_input_two;
	logic cpu_condition_code = 1'b1;
	logic halt_mode = 1'b1;
	logic timer_irq;
	int miscompares = 0;
	int tests_run = 0;
	logic [7:0] d;
	logic [7:0] l1;
	logic [15:0] v;
	logic [15:0] w;
	logic [1:0] sel [3] = '{CLK_DIV2, CLK_DIV4, CLK_DIV8};
	int dv [3] = '{2, 4, 8};

	initial
	begin
		forever #25 clock = ~clock;
	end

	frt_timer dut (.clock(clock), .resetn(resetn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.ext_clock_pin(ext_clock_pin), .capture_input_one(capture_input_one),
		.capture_input_two(capture_input_two), .cpu_condition_code(cpu_condition_code),
		.halt_mode(halt_mode), .timer_irq(timer_irq));

	frt_pins_model pins (.clock(clock), .ext_clock_pin(ext_clock_pin),
		.capture_input_one(capture_input_one), .capture_input_two(capture_input_two));

	// ----------------------------------------
	// bus and compare helpers
	// ----------------------------------------
	// request held until the rising edge that sees waitrequest low; data
	// taken and request released at that edge; the watchdog ends a hang
	task automatic bus(input logic [5:0] a, input logic wr, input logic [7:0] wd,
		output logic [7:0] rd);
		@(posedge clock);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= ~wr;
		avs_writedata <= {24'h000000, wd};
		@(posedge clock);
		while (avs_waitrequest !== 1'b0)
			@(posedge clock);
		rd = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] a, output logic [7:0] x);
		bus(a, 1'b0, 8'h00, x);
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] x);
		logic [7:0] y;
		bus(a, 1'b1, x, y);
	endtask
	task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e)
		begin
			$display("FAIL %s expected %h seen %h", what, e, g);
			miscompares++;
		end
	endtask
	task automatic rc(input logic [5:0] a, input logic [7:0] m, input logic [7:0] e,
		input string what);
		rd(a, d);
		chk(what, {8'h00, e}, {8'h00, d & m});
	endtask
	// high byte first so the low byte comes from the buffer
	task automatic cnt(input logic [5:0] hi, output logic [15:0] x);
		rd(hi, x[15:8]);
		rd(hi + 6'h04, x[7:0]);
	endtask
	task automatic irq_is(input logic e);
		repeat (4) @(posedge clock);
		chk("timer_irq", {15'h0000, e}, {15'h0000, timer_irq});
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// whole run is under a thousand cycles
	initial
	begin
		repeat (30000) @(posedge clock);
		miscompares++;
		tally_and_finish;
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		repeat (10) @(posedge clock);
		resetn <= 1'b1;
		// halt keeps the count frozen so values are exact
		cnt(OFF_COUNT_HIGH, v);
		chk("count after reset", COUNT_RELOAD, v);
		cnt(OFF_SHADOW_HIGH, v);
		chk("shadow after reset", COUNT_RELOAD, v);
		for (int i = 0; i < 3; i++)
		begin
			wr(OFF_CONTROL_TWO, {4'h0, sel[i], 2'h0});
			wr(OFF_COUNT_LOW, 8'h00);
			cnt(OFF_COUNT_HIGH, v);
			chk("reload", COUNT_RELOAD, v);
			halt_mode <= 1'b0;
			repeat (80) @(posedge clock);
			halt_mode <= 1'b1;
			cnt(OFF_COUNT_HIGH, v);
			repeat (20) @(posedge clock);
			cnt(OFF_SHADOW_HIGH, w);
			chk("halted count", v, w);
			w = v - COUNT_RELOAD;
			tests_run++;
			if (int'(w) < 80 / dv[i] - 1 || int'(w) > 80 / dv[i] + 1)
			begin
				$display("FAIL ticks expected %0d seen %0d", 80 / dv[i], w);
				miscompares++;
			end
		end
		// every run above wrapped past FFFF
		wr(OFF_CONTROL_ONE, 8'h20);
		irq_is(1'b0);
		cpu_condition_code <= 1'b0;
		irq_is(1'b1);
		rd(OFF_COUNT_LOW, d);
		rc(OFF_STATUS, 8'h20, 8'h20, "overflow flag");
		rd(OFF_SHADOW_LOW, d);
		rc(OFF_STATUS, 8'h20, 8'h20, "overflow flag");
		rd(OFF_COUNT_LOW, d);
		rc(OFF_STATUS, 8'h20, 8'h00, "overflow flag");
		irq_is(1'b0);
		wr(OFF_SHADOW_LOW, 8'h00);
		rc(OFF_COUNT_HIGH, 8'hFF, 8'hFF, "count high");
		halt_mode <= 1'b0;
		repeat (60) @(posedge clock);
		halt_mode <= 1'b1;
		rd(OFF_SHADOW_HIGH, d);
		rc(OFF_COUNT_LOW, 8'hFF, 8'hFC, "buffered low");
		rd(OFF_COUNT_LOW, l1);
		cnt(OFF_COUNT_HIGH, v);
		chk("live low", v & 16'h00FF, {8'h00, l1});
		// ----------------------------------------
		// capture channels, count frozen at FFFC
		// ----------------------------------------
		wr(OFF_COUNT_LOW, 8'h00);
		wr(OFF_CONTROL_ONE, 8'h82);
		wr(OFF_CONTROL_TWO, 8'h0A);
		pins.cap_level(1, 1'b1);
		rc(OFF_STATUS, 8'h80, 8'h80, "capture one flag");
		irq_is(1'b1);
		rc(OFF_CAP1_HIGH, 8'hFF, 8'hFF, "capture one high");
		rc(OFF_CAP1_LOW, 8'hFF, 8'hFC, "capture one low");
		rc(OFF_STATUS, 8'h80, 8'h00, "capture one flag");
		pins.cap_level(1, 1'b0);
		rc(OFF_STATUS, 8'h80, 8'h00, "capture one flag");
		rd(OFF_CAP2_HIGH, d);
		pins.cap_level(2, 1'b1);
		rc(OFF_STATUS, 8'h10, 8'h00, "capture two flag");
		rd(OFF_CAP2_LOW, d);
		pins.cap_level(2, 1'b0);
		pins.cap_level(2, 1'b1);
		rc(OFF_STATUS, 8'h10, 8'h10, "capture two flag");
		rc(OFF_CAP2_LOW, 8'hFF, 8'hFC, "capture two low");
		rc(OFF_STATUS, 8'h10, 8'h00, "capture two flag");
		wr(OFF_CONTROL_TWO, 8'h8A);
		pins.cap_level(1, 1'b1);
		rc(OFF_STATUS, 8'h80, 8'h00, "capture one flag");
		pins.cap_level(2, 1'b0);
		pins.cap_level(2, 1'b1);
		rc(OFF_STATUS, 8'h10, 8'h10, "capture two flag");
		wr(OFF_CONTROL_TWO, 8'h4A);
		pins.cap_level(1, 1'b0);
		pins.cap_level(1, 1'b1);
		rc(OFF_STATUS, 8'h80, 8'h00, "capture one flag pwm");
		// ----------------------------------------
		// external count clock
		// ----------------------------------------
		wr(OFF_CONTROL_TWO, 8'h0D);
		halt_mode <= 1'b0;
		wr(OFF_COUNT_LOW, 8'h00);
		pins.ext_pulses(5);
		cnt(OFF_COUNT_HIGH, v);
		chk("external rising", 16'h0001, v);
		wr(OFF_CONTROL_TWO, 8'h0C);
		pins.ext_pulses(3);
		cnt(OFF_COUNT_HIGH, v);
		chk("external falling", 16'h0004, v);
		// reset in mid-run must bring the count back to the reload value
		halt_mode <= 1'b1;
		resetn <= 1'b0;
		repeat (2) @(posedge clock);
		resetn <= 1'b1;
		cnt(OFF_SHADOW_HIGH, v);
		chk("count after second reset", COUNT_RELOAD, v);
		tally_and_finish;
	end
endmodule // frt_timer_test
`default_nettype wire
